// File: rtl/bfs_pkg.sv
// Shared constants and types of the boost fault status bank
package bfs_pkg;

  // ****************************************************
  // Widths and register map
  // ****************************************************
  localparam int unsigned  BUS_W      = 32;
  localparam int unsigned  DEC_W      = 8;
  localparam int unsigned  REG_W      = 16;
  localparam int unsigned  NUM_FAULTS = 8;

  localparam logic [7:0]   OFS_FAULT_FLAGS = 8'h10;
  localparam logic [7:0]   OFS_IRQ_STATUS  = 8'h14;
  localparam logic [7:0]   OFS_IRQ_MASK    = 8'h18;
  localparam logic [7:0]   OFS_FAULT_LIVE  = 8'h1C;

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic [15:0]  FAULT_FLAGS_RST = 16'h0000;
  localparam logic [7:0]   IRQ_STATUS_RST  = 8'h00;
  localparam logic [7:0]   IRQ_MASK_RST    = 8'hFF;
  localparam logic [31:0]  RDATA_RST       = 32'h0000_0000;

  // ****************************************************
  // Field layout: fault i has its flag at 2i+1, ack at 2i
  // ****************************************************
  localparam int unsigned  FIELD_STRIDE = 2;
  localparam int unsigned  FLAG_SUB     = 1;
  localparam int unsigned  ACK_SUB      = 0;

  localparam int unsigned  FLT_BOOST_OVERVOLT_LOW  = 0;
  localparam int unsigned  FLT_BOOST_OVERVOLT_HIGH = 1;
  localparam int unsigned  FLT_BOOST_OVERCURRENT   = 2;
  localparam int unsigned  FLT_FREQ_RESISTOR       = 3;
  localparam int unsigned  FLT_SELECT_RESISTOR     = 4;
  localparam int unsigned  FLT_STRING_RESISTOR     = 5;
  localparam int unsigned  FLT_CURRENT_SHORT       = 6;
  localparam int unsigned  FLT_OVERTEMP            = 7;

  localparam int unsigned  POS_OVERTEMP_FLAG       = 15;
  localparam int unsigned  POS_OVERTEMP_ACK        = 14;
  localparam int unsigned  POS_CURRENT_SHORT_FLAG  = 13;
  localparam int unsigned  POS_STRING_MISSING_FLAG = 11;
  localparam int unsigned  POS_SELECT_MISSING_FLAG = 9;
  localparam int unsigned  POS_FREQ_MISSING_FLAG   = 7;
  localparam int unsigned  POS_OVERCURRENT_FLAG    = 5;
  localparam int unsigned  POS_OVERVOLT_HIGH_FLAG  = 3;
  localparam int unsigned  POS_OVERVOLT_LOW_FLAG   = 1;

  // ****************************************************
  // AHB-Lite encodings
  // ****************************************************
  localparam logic [2:0]   HSIZE_WORD = 3'b010;
  localparam logic         HRESP_OKAY = 1'b0;

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WRITE,
    ST_READ
  } bfs_state_e;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [DEC_W-1:0]  addr;
    logic [BUS_W-1:0]  wdata;
  } bfs_req_s;

endpackage

// File: rtl/bfs_fault_cell.sv
// One latched fault flag with its sticky interrupt event bit
`timescale 1ns/1ps
`default_nettype none

module bfs_fault_cell (
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire logic  fault_in,
  input  wire logic  wr_fault,
  input  wire logic  wr_flag,
  input  wire logic  wr_ack,
  input  wire logic  evt_w1c,
  output var  logic  flag_r,
  output var  logic  evt_r
);

  logic  clear_hit;
  logic  set_evt;
  logic  flag_nxt;
  logic  evt_nxt;

  // Only flag and ack written together release the latch
  assign clear_hit = wr_fault & wr_flag & wr_ack;
  assign flag_nxt  = fault_in | (flag_r & ~clear_hit);
  assign set_evt   = fault_in & (~flag_r | clear_hit);
  // Fresh latch wins over any clear of the event bit
  assign evt_nxt   = set_evt | (evt_r & ~(evt_w1c | clear_hit));

  always_ff @(posedge clk) begin
    if (rst) begin
      flag_r <= 1'b0;
      evt_r  <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      evt_r  <= evt_nxt;
    end
  end

endmodule

`default_nettype wire

// File: rtl/bfs_irq_gate.sv
// Interrupt mask register and level interrupt output
`timescale 1ns/1ps
`default_nettype none

module bfs_irq_gate #(
  parameter int unsigned  N = 8
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          wr_mask,
  input  wire logic [N-1:0]  wdata,
  input  wire logic [N-1:0]  evt,
  output var  logic [N-1:0]  mask_r,
  output var  logic          irq_r
);

  logic          irq_nxt;
  logic [N-1:0]  mask_nxt;

  assign mask_nxt = wr_mask ? wdata : mask_r;
  assign irq_nxt  = |(evt & mask_r);

  always_ff @(posedge clk) begin
    if (rst) begin
      mask_r <= bfs_pkg::IRQ_MASK_RST[N-1:0];
      irq_r  <= 1'b0;
    end else begin
      mask_r <= mask_nxt;
      irq_r  <= irq_nxt;
    end
  end

endmodule

`default_nettype wire

// File: rtl/bfs_top.sv
// Boost fault status register bank behind an AHB-Lite slave
//
// Behaviour
// - Fault register at offset 0x10, 16 bits, all zero after reset.
// - Bit 15 latches the over-temperature shutdown fault.
// - Bit 13 latches current-setting resistor shorted to ground.
// - Bit 11 latches missing LED string configuration resistor.
// - Bit 9 latches missing mode-select resistor.
// - Bit 7 latches missing boost frequency resistor.
// - Bit 5 latches boost over-current.
// - Bit 3 latches upper boost over-voltage threshold trip.
// - Bit 1 latches lower boost over-voltage threshold trip.
// - Each flag has its clear bit just below, at even positions 14..0.
// - Writing one to flag and clear together clears flag and interrupt, unless that fault input is still high: then both stay set.
`timescale 1ns/1ps
`default_nettype none

module bfs_top (
  input  wire logic         CLK_SYS,
  input  wire logic         SYS_RST,
  input  wire logic         HSEL,
  input  wire logic [31:0]  HADDR,
  input  wire logic [1:0]   HTRANS,
  input  wire logic         HWRITE,
  input  wire logic [2:0]   HSIZE,
  input  wire logic [31:0]  HWDATA,
  input  wire logic         HREADY,
  output var  logic [31:0]  HRDATA,
  output var  logic         HREADYOUT,
  output var  logic         HRESP,
  input  wire logic [7:0]   FAULT_IN,
  output var  logic [7:0]   FAULT_LATCHED,
  output var  logic         IRQ
);

  localparam int unsigned  NF = bfs_pkg::NUM_FAULTS;
  localparam int unsigned  DW = bfs_pkg::DEC_W;
  localparam int unsigned  RW = bfs_pkg::REG_W;
  localparam int unsigned  BW = bfs_pkg::BUS_W;

  // ****************************************************
  // Bus slave state
  // ****************************************************
  bfs_pkg::bfs_state_e  state_r;
  bfs_pkg::bfs_state_e  state_nxt;
  logic [DW-1:0]        addr_r;
  logic                 word_r;
  logic                 hreadyout_r;
  logic [BW-1:0]        hrdata_r;
  logic [BW-1:0]        hrdata_nxt;
  logic [DW-1:0]        addr_nxt;
  logic                 word_nxt;

  wire                  accept = HSEL & HTRANS[1] & HREADY;
  wire                  is_word = (HSIZE == bfs_pkg::HSIZE_WORD);

  always_comb begin
    case (state_r)
      bfs_pkg::ST_READ: begin
        state_nxt = bfs_pkg::ST_IDLE;
      end
      bfs_pkg::ST_IDLE,
      bfs_pkg::ST_WRITE: begin
        if (accept) begin
          state_nxt = HWRITE ? bfs_pkg::ST_WRITE : bfs_pkg::ST_READ;
        end else begin
          state_nxt = bfs_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = bfs_pkg::ST_IDLE;
      end
    endcase
  end

  assign addr_nxt = accept ? HADDR[DW-1:0] : addr_r;
  assign word_nxt = accept ? is_word : word_r;

  // ****************************************************
  // Request carried to the register file
  // ****************************************************
  bfs_pkg::bfs_req_s  req;

  assign req.wr    = (state_r == bfs_pkg::ST_WRITE) & word_r;
  assign req.rd    = (state_r == bfs_pkg::ST_READ);
  assign req.addr  = addr_r;
  assign req.wdata = HWDATA;

  wire  sel_fault = (req.addr == bfs_pkg::OFS_FAULT_FLAGS);
  wire  sel_stat  = (req.addr == bfs_pkg::OFS_IRQ_STATUS);
  wire  sel_mask  = (req.addr == bfs_pkg::OFS_IRQ_MASK);
  wire  sel_live  = (req.addr == bfs_pkg::OFS_FAULT_LIVE);

  wire  wr_fault  = req.wr & sel_fault;
  wire  wr_stat   = req.wr & sel_stat;
  wire  wr_mask   = req.wr & sel_mask;

  // ****************************************************
  // Fault latches, one per fault, flag over its ack bit
  // ****************************************************
  logic [NF-1:0]  flag;
  logic [NF-1:0]  evt;
  logic [NF-1:0]  mask;
  logic [RW-1:0]  fault_word;
  logic           irq_q;
  logic [7:0]     live_r;

  genvar gi;
  generate
    for (gi = 0; gi < NF; gi++) begin : g_fault
      localparam int unsigned  PF = gi * bfs_pkg::FIELD_STRIDE + bfs_pkg::FLAG_SUB;
      localparam int unsigned  PA = gi * bfs_pkg::FIELD_STRIDE + bfs_pkg::ACK_SUB;

      bfs_fault_cell u_cell (
        .clk      (CLK_SYS),
        .rst      (SYS_RST),
        .fault_in (FAULT_IN[gi]),
        .wr_fault (wr_fault),
        .wr_flag  (req.wdata[PF]),
        .wr_ack   (req.wdata[PA]),
        .evt_w1c  (wr_stat & req.wdata[gi]),
        .flag_r   (flag[gi]),
        .evt_r    (evt[gi])
      );

      // Ack bits are write-only and read back as zero
      assign fault_word[PF] = flag[gi];
      assign fault_word[PA] = 1'b0;
    end
  endgenerate

  bfs_irq_gate #(
    .N (NF)
  ) u_irq (
    .clk     (CLK_SYS),
    .rst     (SYS_RST),
    .wr_mask (wr_mask),
    .wdata   (req.wdata[NF-1:0]),
    .evt     (evt),
    .mask_r  (mask),
    .irq_r   (irq_q)
  );

  // ****************************************************
  // Read data selection
  // ****************************************************
  wire [BW-1:0]  rd_fault = {{(BW-RW){1'b0}}, fault_word};
  wire [BW-1:0]  rd_stat  = {{(BW-NF){1'b0}}, evt};
  wire [BW-1:0]  rd_mask  = {{(BW-NF){1'b0}}, mask};
  wire [BW-1:0]  rd_live  = {{(BW-8){1'b0}}, live_r};

  wire [BW-1:0]  rd_mux = sel_fault ? rd_fault :
                          sel_stat  ? rd_stat  :
                          sel_mask  ? rd_mask  :
                          sel_live  ? rd_live  : bfs_pkg::RDATA_RST;

  assign hrdata_nxt = (req.rd & word_r) ? rd_mux : bfs_pkg::RDATA_RST;

  // ****************************************************
  // Registers
  // ****************************************************
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      state_r     <= bfs_pkg::ST_IDLE;
      addr_r      <= '0;
      word_r      <= 1'b0;
      hreadyout_r <= 1'b1;
      hrdata_r    <= bfs_pkg::RDATA_RST;
      live_r      <= '0;
    end else begin
      state_r     <= state_nxt;
      addr_r      <= addr_nxt;
      word_r      <= word_nxt;
      hreadyout_r <= (state_nxt != bfs_pkg::ST_READ);
      hrdata_r    <= hrdata_nxt;
      live_r      <= FAULT_IN;
    end
  end

  assign HRDATA        = hrdata_r;
  assign HREADYOUT     = hreadyout_r;
  assign HRESP         = bfs_pkg::HRESP_OKAY;
  assign FAULT_LATCHED = flag;
  assign IRQ           = irq_q;

endmodule

`default_nettype wire

// File: sim/bfs_top_monitor.sv
// Port checker of the boost fault status bank
`timescale 1ns/1ps
`default_nettype none
module bfs_top_monitor (
  input  wire logic         CLK_SYS,
  input  wire logic         SYS_RST,
  input  wire logic         HSEL,
  input  wire logic [31:0]  HADDR,
  input  wire logic [1:0]   HTRANS,
  input  wire logic         HWRITE,
  input  wire logic [2:0]   HSIZE,
  input  wire logic [31:0]  HWDATA,
  input  wire logic         HREADY,
  input  wire logic [31:0]  HRDATA,
  input  wire logic         HREADYOUT,
  input  wire logic         HRESP,
  input  wire logic [7:0]   FAULT_IN,
  input  wire logic [7:0]   FAULT_LATCHED
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  wire         acc = HSEL && HTRANS[1] && HREADY;
  logic        wr_ph;
  logic [7:0]  pairs;
  // Flag and ack both set, per fault
  always_comb for (int i = 0; i < 8; i++) pairs[i] = HWDATA[2*i+1] & HWDATA[2*i];
  // Data phase of a write to the fault register
  // Non-word writes are ignored by the bank
  always_ff @(posedge CLK_SYS) wr_ph <= !SYS_RST && acc && HWRITE
                                        && HSIZE == bfs_pkg::HSIZE_WORD
                                        && HADDR[7:0] == bfs_pkg::OFS_FAULT_FLAGS;
  property p_latch;
    FAULT_IN != 8'h00 |=> (FAULT_LATCHED & $past(FAULT_IN)) == $past(FAULT_IN);
  endproperty
  a_latch:
    assert property (p_latch) else $error("fault not latched");
  property p_wr; acc && HWRITE |=> HREADYOUT; endproperty
  a_wr: assert property (p_wr) else $error("write stalled");
  property p_rd; acc && !HWRITE |=> !HREADYOUT ##1 HREADYOUT; endproperty
  a_rd: assert property (p_rd) else $error("read timing wrong");
  property p_rdz; $past(HREADYOUT) |-> HRDATA == 32'h0000_0000; endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside answer");
  property p_okay; HRESP == bfs_pkg::HRESP_OKAY; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_clr;
    wr_ph |=> (FAULT_LATCHED & $past(pairs) & ~$past(FAULT_IN)) == 8'h00;
  endproperty
  a_clr: assert property (p_clr) else $error("paired clear ignored");
  property p_keep;
    wr_ph |=> ($past(FAULT_LATCHED) & ~FAULT_LATCHED & ~$past(pairs)) == 8'h00;
  endproperty
  a_keep: assert property (p_keep) else $error("unpaired write cleared");
  property p_hold; !wr_ph |=> ($past(FAULT_LATCHED) & ~FAULT_LATCHED) == 8'h00; endproperty
  a_hold: assert property (p_hold) else $error("flag dropped");
  property p_noset;
    1'b1 |=> (FAULT_LATCHED & ~$past(FAULT_LATCHED) & ~$past(FAULT_IN)) == 8'h00;
  endproperty
  a_noset: assert property (p_noset) else $error("flag set without fault");
endmodule
bind bfs_top bfs_top_monitor u_bfs_top_monitor (
  .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .FAULT_IN(FAULT_IN), .FAULT_LATCHED(FAULT_LATCHED));
`default_nettype wire

// File: sim/boost_fault_status_bank_tb_top.sv
// Self-checking bench of the boost fault status bank
`timescale 1ns/1ps
`default_nettype none
module boost_fault_status_bank_tb_top;
  logic        clk = 0, rst = 1, hsel = 0, hwrite = 0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010, sz = 3'b010;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
  logic [7:0]  flt = 8'h00;
  wire  [31:0] hrdata;
  wire         hready, hresp, irq;
  wire  [7:0]  latched;
  int          n_errors = 0, total_checks = 0;
  bfs_top u_bfs_top (
    .CLK_SYS(clk), .SYS_RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .FAULT_IN(flt), .FAULT_LATCHED(latched), .IRQ(irq));
  initial forever #10 clk = ~clk;
  // ****************************************************
  // Tasks
  // ****************************************************
  task automatic results();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 20);
    if (hready !== 1'b1) begin
      n_errors++;
      $display("mismatch at %0t: bus hang", $time);
      results();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= sz;
    haddr <= {24'h00_0000, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic pulse(input logic [7:0] f);
    flt <= f;
    @(posedge clk);
    flt <= 8'h00;
    repeat (2) @(posedge clk);
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  // ****************************************************
  // Sequence
  // ****************************************************
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h10, 32'h0);
    rd(8'h18, 32'h0000_00FF);
    irq_is(1'b0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i);
      rd(8'h10, 32'h1 << (2 * i + 1));
      rd(8'h14, 32'h1 << i);
      wr(8'h10, 32'h1 << (2 * i + 1));
      wr(8'h10, 32'h1 << (2 * i));
      rd(8'h10, 32'h1 << (2 * i + 1));
      irq_is(1'b1);
      wr(8'h10, 32'h3 << (2 * i));
      irq_is(1'b0);
      rd(8'h10, 32'h0);
      rd(8'h14, 32'h0);
    end
    $display("test flags done");
    flt <= 8'h80;
    repeat (2) @(posedge clk);
    wr(8'h10, 32'h0000_C000);
    rd(8'h10, 32'h0000_8000);
    rd(8'h1C, 32'h0000_0080);
    flt <= 8'h00;
    rd(8'h10, 32'h0000_8000);
    wr(8'h10, 32'h0000_FFFF);
    rd(8'h10, 32'h0);
    wr(8'h10, 32'h0000_AAAA);
    rd(8'h10, 32'h0);
    chk({24'h0, latched}, 32'h0);
    $display("test relatch done");
    pulse(8'h01);
    wr(8'h18, 32'h0);
    irq_is(1'b0);
    wr(8'h18, 32'h0000_00FF);
    irq_is(1'b1);
    wr(8'h14, 32'h0000_0001);
    irq_is(1'b0);
    rd(8'h10, 32'h0000_0002);
    sz = 3'b000;
    wr(8'h10, 32'h0000_0003);
    rd(8'h10, 32'h0);
    sz = bfs_pkg::HSIZE_WORD;
    rd(8'h10, 32'h0000_0002);
    wr(8'h10, 32'h0000_0003);
    rd(8'h10, 32'h0);
    $display("test interrupt done");
    rd(8'h20, 32'h0);
    wr(8'h1C, 32'h0000_00FF);
    rd(8'h1C, 32'h0);
    pulse(8'h10);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h10, 32'h0);
    $display("test refusal and reset done");
    results();
  end
endmodule
`default_nettype wire
